// File: core/mode_reg_two_three_calib_read.sv
/*
  second and third mode registers with calibration readout control.
  assumes command pins synchronous to clk, read latency and additive field come from the first register.
*/
`timescale 1ns/1ns
`default_nettype none
module mode_reg_two_three_calib_read
  import mode_reg_pkg::*;
#(
  parameter int CAL_W = 8,
  parameter logic [CAL_W-1:0] CAL_PATTERN = 8'h55
)
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // command pins
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [mode_reg_pkg::BANK_W-1:0] bank_addr,
  input wire logic [mode_reg_pkg::ADDR_W-1:0] addr,
  // from first mode register and core
  input wire logic [1:0] additive_latency_sel,
  input wire logic [4:0] read_latency,
  input wire logic write_leveling,
  input wire logic write_active,
  input wire logic self_refresh_active,
  // configuration outputs
  output logic [mode_reg_pkg::ADDR_W-1:0] latency_refresh_term_config,
  output logic [mode_reg_pkg::ADDR_W-1:0] calibration_readout_config,
  output logic self_refresh_temp_range,
  output logic automatic_self_refresh,
  output logic [4:0] column_write_latency,
  output logic [5:0] total_write_latency,
  output logic [1:0] write_term_value,
  output logic dynamic_term_active,
  // calibration readout
  output logic cal_mode,
  output logic read_from_cal,
  output logic [CAL_W-1:0] cal_data,
  output logic cal_data_valid
);
  import mode_reg_pkg::*;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  function automatic logic is_load(input logic c, r, a, w);
    is_load = !c && !r && !a && !w;
  endfunction

  function automatic logic is_read(input logic c, r, a, w);
    is_read = !c && !r && a && w;
  endfunction

  logic load_lat_cfg;
  logic load_cal_cfg;
  logic read_cmd;
  // bank bit 2 ignored; the controller drives it zero only on loads
  assign load_lat_cfg = is_load(cs_n, ras_n, cas_n, we_n) && bank_addr[1:0] == SEL_LAT_CFG;
  assign load_cal_cfg = is_load(cs_n, ras_n, cas_n, we_n) && bank_addr[1:0] == SEL_CAL_CFG;
  assign read_cmd = is_read(cs_n, ras_n, cas_n, we_n);

  // ----------------------------------------
  // mode registers
  // ----------------------------------------
  logic [ADDR_W-1:0] lat_cfg_r;
  logic [ADDR_W-1:0] cal_cfg_r;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      lat_cfg_r <= LAT_CFG_RESET;
    else if (clk_en && load_lat_cfg)
      lat_cfg_r <= addr;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cal_cfg_r <= CAL_CFG_RESET;
    else if (clk_en && load_cal_cfg)
      cal_cfg_r <= addr;
  end

  // ----------------------------------------
  // latency
  // ----------------------------------------
  logic [4:0] col_lat_nxt;
  logic [5:0] tot_lat_nxt;

  write_latency_calc u_lat (
    .wr_lat_code(lat_cfg_r[WR_LAT_HI:WR_LAT_LO]),
    .add_lat_code(additive_latency_sel),
    .read_latency(read_latency),
    .column_write_latency(col_lat_nxt),
    .total_write_latency(tot_lat_nxt)
  );

  // ----------------------------------------
  // calibration mode state
  // ----------------------------------------
  cal_state_t state_r;
  cal_state_t state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_NORMAL:
        if (load_cal_cfg && addr[CAL_EN_BIT])
          state_nxt = ST_CAL;
      ST_CAL:
        if (load_cal_cfg && !addr[CAL_EN_BIT])
          state_nxt = ST_NORMAL;
      default:
        state_nxt = ST_NORMAL;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state_r <= ST_NORMAL;
    else if (clk_en)
      state_r <= state_nxt;
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  // outputs lag the register by one cycle so every port is a flop
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      latency_refresh_term_config <= LAT_CFG_RESET;
      calibration_readout_config <= CAL_CFG_RESET;
    end
    else if (clk_en)
    begin
      latency_refresh_term_config <= lat_cfg_r;
      calibration_readout_config <= cal_cfg_r;
    end
  end

  // refresh options only reported; the array itself is elsewhere
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      self_refresh_temp_range <= 1'b0;
      automatic_self_refresh <= 1'b0;
    end
    else if (clk_en)
    begin
      self_refresh_temp_range <= lat_cfg_r[TEMP_RANGE_BIT];
      automatic_self_refresh <= lat_cfg_r[AUTO_REFRESH_BIT];
    end
  end

  // latency sum follows first-register levels a cycle late
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      column_write_latency <= WR_LAT_BASE;
      total_write_latency <= {1'b0, WR_LAT_BASE};
    end
    else if (clk_en)
    begin
      column_write_latency <= col_lat_nxt;
      total_write_latency <= tot_lat_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      write_term_value <= RTT_OFF;
    else if (clk_en)
      write_term_value <= lat_cfg_r[WR_TERM_HI:WR_TERM_LO];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cal_mode <= 1'b0;
    else if (clk_en)
      cal_mode <= (state_r == ST_CAL);
  end

  // nominal termination is not consulted: write value stands alone
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      dynamic_term_active <= 1'b0;
    else if (clk_en)
      dynamic_term_active <= write_active && !write_leveling &&
                             lat_cfg_r[WR_TERM_HI:WR_TERM_LO] != RTT_OFF;
  end

  // partial-array range field is not modelled; self-refresh state is only observed
  logic unused_sr;
  assign unused_sr = self_refresh_active;

  // ----------------------------------------
  // calibration readout
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      read_from_cal <= 1'b0;
      cal_data <= '0;
      cal_data_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      read_from_cal <= read_cmd && state_r == ST_CAL;
      cal_data_valid <= read_cmd && state_r == ST_CAL;
      cal_data <= (read_cmd && state_r == ST_CAL) ? CAL_PATTERN : '0;
    end
  end
endmodule
`default_nettype wire

// File: core/mode_reg_pkg.sv
/*
  constants for the second and third mode register bank: command decode, field positions, latency coding.
  assumes command pins are sampled on the rising device clock, active low strobes.

// What this block does
// - all strobes low with bank 10 loads the second mode register from address pins.
// - all strobes low with bank 11 loads the third; banks 00..11 pick registers 0..3.
// - bit 7 selects normal or extended self-refresh temperature range.
// - bit 6 enables automatic self-refresh, else manual range bit applies.
// - bits 5..3 code write latency, 000 is 5 cycles up to 12.
// - column write latency counts cycles from internal write to first data.
// - only whole-cycle latencies exist, no half-cycle setting.
// - total write latency is additive latency plus column write latency.
// - bits 10 and 9 hold the write-time termination value.
// - write termination applies during writes even with nominal termination off.
// - during write leveling only nominal termination, no dynamic termination.
// - partial-array self-refresh loses data outside range once self-refresh entered.
// - third register bit 2 set enables calibration readout mode.
// - in calibration mode reads come from the calibration register.
// - reset works even with calibration readout enabled.
// - calibration readout returns a fixed predefined pattern.
// - additive latency from first register is zero, read latency minus one or two.
*/
package mode_reg_pkg;
  localparam int ADDR_W = 16;
  localparam int BANK_W = 3;
  localparam logic [1:0] SEL_LAT_CFG = 2'h2;
  localparam logic [1:0] SEL_CAL_CFG = 2'h3;
  localparam logic [15:0] LAT_CFG_RESET = 16'h0000;
  localparam logic [15:0] CAL_CFG_RESET = 16'h0000;
  localparam int TEMP_RANGE_BIT = 7;
  localparam int AUTO_REFRESH_BIT = 6;
  localparam int WR_LAT_LO = 3;
  localparam int WR_LAT_HI = 5;
  localparam int WR_TERM_LO = 9;
  localparam int WR_TERM_HI = 10;
  localparam int CAL_EN_BIT = 2;
  localparam logic [4:0] WR_LAT_BASE = 5'h05;
  localparam logic [1:0] ADD_LAT_OFF = 2'h0;
  localparam logic [1:0] ADD_LAT_RL1 = 2'h1;
  localparam logic [1:0] ADD_LAT_RL2 = 2'h2;
  localparam logic [4:0] ADD_LAT_SUB1 = 5'h01;
  localparam logic [4:0] ADD_LAT_SUB2 = 5'h02;
  localparam logic [4:0] ADD_LAT_ZERO = 5'h00;
  localparam logic [1:0] RTT_OFF = 2'h0;
  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_CAL = 2'b01
  } cal_state_t;
endpackage

// File: core/write_latency_calc.sv
/*
  sums additive and column write latency into the total write latency.
  assumes a caller supplies the registered read latency and first-register field.
*/
`timescale 1ns/1ns
`default_nettype none
module write_latency_calc
  import mode_reg_pkg::*;
(
  // inputs
  input wire logic [2:0] wr_lat_code,
  input wire logic [1:0] add_lat_code,
  input wire logic [4:0] read_latency,
  // result
  output logic [4:0] column_write_latency,
  output logic [5:0] total_write_latency
);
  logic [4:0] additive_latency;
  always_comb
  begin
    column_write_latency = WR_LAT_BASE + {2'h0, wr_lat_code};
    case (add_lat_code)
      ADD_LAT_RL1: additive_latency = read_latency - ADD_LAT_SUB1;
      ADD_LAT_RL2: additive_latency = read_latency - ADD_LAT_SUB2;
      // reserved code falls back to no added latency
      default: additive_latency = ADD_LAT_ZERO;
    endcase
    total_write_latency = {1'b0, additive_latency} + {1'b0, column_write_latency};
  end
endmodule
`default_nettype wire

// File: bench/mode_reg_sva.sv
/*
  port checker for the second and third mode register bank.
  assumes binding onto the top module, one clock, sync reset.
*/
`timescale 1ns/1ns
`default_nettype none
module mode_reg_sva
  import mode_reg_pkg::*;
#(
  parameter int CAL_W = 8,
  parameter logic [CAL_W-1:0] CAL_PATTERN = 8'h55
)
(
  // clock, reset, command pins
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] bank_addr,
  input wire logic [15:0] addr,
  // core levels
  input wire logic [1:0] additive_latency_sel,
  input wire logic [4:0] read_latency,
  input wire logic write_leveling,
  input wire logic write_active,
  // outputs watched
  input wire logic [15:0] latency_refresh_term_config,
  input wire logic [4:0] column_write_latency,
  input wire logic [5:0] total_write_latency,
  input wire logic [1:0] write_term_value,
  input wire logic dynamic_term_active,
  input wire logic cal_mode,
  input wire logic read_from_cal,
  input wire logic [CAL_W-1:0] cal_data,
  input wire logic cal_data_valid
);
  default clocking cb @(posedge clk); endclocking
  // a frozen cycle stalls the whole pipeline, so no opinion then
  default disable iff (sys_rst || !clk_en);
  // ----------
  // checks
  // ----------
  wire logic ld2 = !cs_n && !ras_n && !cas_n && !we_n && bank_addr[1:0] == 2'h2;
  wire logic ld3 = !cs_n && !ras_n && !cas_n && !we_n && bank_addr[1:0] == 2'h3;
  wire logic rd = !cs_n && !ras_n && cas_n && we_n;
  // code 3 never driven; it is checked like code 0, with no added latency
  wire logic [5:0] exp_total = {1'b0, column_write_latency} + (additive_latency_sel == 2'h1 ? {1'b0, read_latency} - 6'h01
    : additive_latency_sel == 2'h2 ? {1'b0, read_latency} - 6'h02 : 6'h00);
  property p_load; ld2 |-> ##2 latency_refresh_term_config == $past(addr, 2); endproperty
  a_load: assert property (p_load) else $error("second register copy wrong");
  property p_cwl; ld2 |-> ##2 column_write_latency == 5'h05 + {2'h0, $past(addr[5:3], 2)}; endproperty
  a_cwl: assert property (p_cwl) else $error("column write latency wrong");
  property p_term; ld2 |-> ##2 write_term_value == $past(addr[10:9], 2); endproperty
  a_term: assert property (p_term) else $error("write termination wrong");
  property p_wl; ($stable(additive_latency_sel) && $stable(read_latency) && $stable(column_write_latency)) [*3]
    |-> total_write_latency == exp_total; endproperty
  a_wl: assert property (p_wl) else $error("total write latency wrong");
  property p_dyn; write_active && !write_leveling && write_term_value != 2'h0 && !$past(ld2) |=> dynamic_term_active;
  endproperty
  a_dyn: assert property (p_dyn) else $error("dynamic termination missing");
  property p_lvl; write_leveling |=> !dynamic_term_active; endproperty
  a_lvl: assert property (p_lvl) else $error("dynamic termination in leveling");
  property p_cal; ld3 |-> ##2 cal_mode == $past(addr[2], 2); endproperty
  a_cal: assert property (p_cal) else $error("calibration mode wrong");
  // a read right behind a third-register load already sees the new mode while cal_mode still shows the old
  property p_rd; rd && cal_mode && !$past(ld3) |=> read_from_cal && cal_data_valid && cal_data == CAL_PATTERN;
  endproperty
  a_rd: assert property (p_rd) else $error("calibration read wrong");
  property p_idle; rd && !cal_mode && !$past(ld3) |=> !read_from_cal && !cal_data_valid && cal_data == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("read redirected outside calibration mode");
  property p_hold; !ld2 |-> ##2 $stable(latency_refresh_term_config); endproperty
  a_hold: assert property (p_hold) else $error("second register changed");
endmodule
bind mode_reg_two_three_calib_read mode_reg_sva #(.CAL_W(CAL_W), .CAL_PATTERN(CAL_PATTERN)) sva_u (.clk, .sys_rst, .clk_en,
  .cs_n, .ras_n, .cas_n, .we_n, .bank_addr, .addr, .additive_latency_sel, .read_latency, .write_leveling,
  .write_active, .latency_refresh_term_config, .column_write_latency, .total_write_latency, .write_term_value,
  .dynamic_term_active, .cal_mode, .read_from_cal, .cal_data, .cal_data_valid);
`default_nettype wire

// File: bench/cmd_ctrl_model.sv
/*
  behavioural memory controller driving the command pins.
  assumes the device samples the pins on the rising clock.
*/
`timescale 1ns/1ns
`default_nettype none
module cmd_ctrl_model
(
  // clock
  input wire logic clk,
  // command pins
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] bank_addr,
  output logic [15:0] addr
);
  // ----------
  // commands
  // ----------
  initial
  begin
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    bank_addr = 3'h0;
    addr = 16'h0000;
  end
  // deselect leaves junk, never the old value
  task automatic cmd(input logic [3:0] strobes, input logic [2:0] bank, input logic [15:0] a);
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= strobes;
    bank_addr <= bank;
    addr <= a;
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= {1'b1, ~strobes[2:0]};
    bank_addr <= ~bank;
    addr <= ~a;
  endtask
  task automatic mrs2(input logic [15:0] a);
    cmd(4'h0, 3'h2, a & 16'h06F8);
  endtask
  task automatic mrs3(input logic [15:0] a);
    cmd(4'h0, 3'h3, a & 16'h0004);
  endtask
endmodule
`default_nettype wire

// File: bench/tb_top.sv
/*
  self-checking bench for the mode register bank.
  assumes the controller model and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import mode_reg_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, write_leveling = 1'b0, write_active = 1'b0;
  logic self_refresh_active = 1'b0, cs_n, ras_n, cas_n, we_n, self_refresh_temp_range, automatic_self_refresh;
  logic dynamic_term_active, cal_mode, read_from_cal, cal_data_valid;
  logic [2:0] bank_addr;
  logic [15:0] addr, latency_refresh_term_config, calibration_readout_config, v;
  logic [1:0] additive_latency_sel = 2'h0, write_term_value;
  logic [4:0] read_latency = 5'h06, column_write_latency;
  logic [5:0] total_write_latency;
  logic [7:0] cal_data;
  int bad_count = 0, cmp_count = 0, cyc = 0;
  cmd_ctrl_model ctl_u (.clk, .cs_n, .ras_n, .cas_n, .we_n, .bank_addr, .addr);
  mode_reg_two_three_calib_read #(.CAL_PATTERN(8'hA6)) dut_u (.clk, .sys_rst, .clk_en, .cs_n, .ras_n, .cas_n, .we_n,
    .bank_addr, .addr, .additive_latency_sel, .read_latency, .write_leveling, .write_active, .self_refresh_active,
    .latency_refresh_term_config, .calibration_readout_config, .self_refresh_temp_range, .automatic_self_refresh,
    .column_write_latency, .total_write_latency, .write_term_value, .dynamic_term_active, .cal_mode,
    .read_from_cal, .cal_data, .cal_data_valid);
  // ----------
  // helpers
  // ----------
  initial forever #4 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic logic [5:0] exp_total(input logic [2:0] c, input logic [1:0] s, input logic [4:0] rl);
    exp_total = 6'h05 + c + (s == 2'h1 ? rl - 6'h01 : s == 2'h2 ? rl - 6'h02 : 6'h00);
  endfunction
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic read_cal(input logic [9:0] exp);
    ctl_u.cmd(4'h3, 3'($urandom), 16'($urandom));
    #1;
    check({read_from_cal, cal_data_valid, cal_data}, exp);
  endtask
  // random levels, plus the hang guard
  always @(posedge clk)
  begin
    write_active <= 1'($urandom);
    write_leveling <= 1'($urandom % 4 == 0);
    self_refresh_active <= 1'($urandom);
    cyc++;
    if (cyc > 1000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  initial
  begin
    void'($urandom(74));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    check({column_write_latency, total_write_latency}, {5'h05, 6'h05});
    for (int i = 0; i < 8; i++)
    begin
      v = 16'($urandom);
      v[5:3] = i[2:0];
      @(posedge clk);
      additive_latency_sel <= 2'($urandom % 3);
      read_latency <= 5'h06 + 5'($urandom % 8);
      ctl_u.mrs2(v);
      settle();
      check(latency_refresh_term_config, v & 16'h06F8);
      check(16'(column_write_latency), 16'(5 + i));
      check(total_write_latency, exp_total(i[2:0], additive_latency_sel, read_latency));
      check({self_refresh_temp_range, automatic_self_refresh, write_term_value}, {v[7:6], v[10:9]});
    end
    for (int b = 0; b < 2; b++)
    begin
      ctl_u.cmd(4'h0, 3'(b), 16'hFFFF);
      settle();
      check(latency_refresh_term_config, v & 16'h06F8);
    end
    // a load while the clock enable is low must not land
    @(posedge clk);
    clk_en <= 1'b0;
    ctl_u.mrs2(~v);
    settle();
    check(latency_refresh_term_config, v & 16'h06F8);
    @(posedge clk);
    clk_en <= 1'b1;
    ctl_u.mrs2(16'h0040);
    settle();
    check({automatic_self_refresh, self_refresh_temp_range, write_term_value, dynamic_term_active}, 5'h10);
    read_cal(10'h000);
    ctl_u.mrs3(16'hFFFF);
    settle();
    check({cal_mode, calibration_readout_config}, 17'h10004);
    read_cal(10'h3A6);
    read_cal(10'h3A6);
    ctl_u.mrs3(16'h0000);
    settle();
    read_cal(10'h000);
    ctl_u.mrs3(16'h0004);
    settle();
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    check({cal_mode, latency_refresh_term_config}, 17'h00000);
    print_verdict();
  end
endmodule
`default_nettype wire
